// ### hw/plcsr_defines.svh
`ifndef PLCSR_DEFINES_SVH
`define PLCSR_DEFINES_SVH

// Register offsets in configuration space
`define PLCSR_CMD_OFF 8'h04
`define PLCSR_STAT_OFF 8'h06

// Command register fields
`define PLCSR_CMD_IO_BIT 0
`define PLCSR_CMD_MEM_BIT 1
`define PLCSR_CMD_MASTER_BIT 2
`define PLCSR_CMD_SPECIAL_BIT 3
`define PLCSR_CMD_MWI_BIT 4
`define PLCSR_CMD_PALETTE_BIT 5
`define PLCSR_CMD_PERR_BIT 6
`define PLCSR_CMD_STEP_BIT 7
`define PLCSR_CMD_SERR_BIT 8
`define PLCSR_CMD_B2B_BIT 9
`define PLCSR_CMD_WR_MASK 16'h0156
`define PLCSR_CMD_RESET 16'h0000

// Status register fields
`define PLCSR_ST_CAPS_BIT 4
`define PLCSR_ST_HISPEED_BIT 5
`define PLCSR_ST_USERFEAT_BIT 6
`define PLCSR_ST_B2B_BIT 7
`define PLCSR_ST_DPREP_BIT 8
`define PLCSR_ST_TABSIG_BIT 11
`define PLCSR_ST_TABREC_BIT 12
`define PLCSR_ST_IABORT_BIT 13
`define PLCSR_ST_SYSERR_BIT 14
`define PLCSR_ST_PARERR_BIT 15
`define PLCSR_ST_W1C_MASK 16'hF900
`define PLCSR_ST_FIXED 16'h0210
`define PLCSR_ST_RESET 16'h0210
`define PLCSR_ST_STICKY_RESET 16'h0000
`define PLCSR_DEVSEL_MEDIUM 2'h1

// Initiator write command codes
`define PLCSR_BUSCMD_MEMWR 4'h7
`define PLCSR_BUSCMD_MWI 4'hF

`endif

// ### hw/plcsr_pkg.sv
package plcsr_pkg;
   typedef logic [15:0] plcsr_half_t;
   typedef logic [31:0] plcsr_word_t;
   typedef logic [3:0] plcsr_buscmd_t;
endpackage

// ### hw/plcsr_regs.sv
// Function
// - Reserved command and status bits read zero
// - Fast back-to-back enable reads zero, never used
// - Command bit 8 gates system error drive
// - Stepping control hardwired zero, no stepping
// - Command bit 6 gates parity error drive
// - Palette snoop enable reads zero
// - Bit 4 selects write-invalidate over memory write
// - Special cycle enable zero, special cycles ignored
// - Initiating transactions only with bit 2 set
// - Memory cycles claimed only with bit 1
// - I/O space enable zero, never claimed
// - Status 15 set on any parity error
// - Status 14 set when system error signaled
// - Status 13 set on received master abort
// - Status 12 set on received target abort
// - Status 11 set on signaled target abort
// - DEVSEL timing reads 01b, medium decode
// - Status 8 needs perr, mastership, response enabled
// - Fast back-to-back capable hardwired zero
// - User definable features bit hardwired zero
// - High speed capable bit hardwired zero
// - Capability list present always reads one
// - Sticky flags clear only on written one or reset
`timescale 1ns/1ps
`include "plcsr_defines.svh"

module plcsr_regs
   import plcsr_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Configuration access
   input wire logic cfg_rd_i,
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic cfg_rvalid_o,
   output logic [31:0] cfg_rdata_o,
   // Bus interface events
   input wire logic addr_parity_error_detected_i,
   input wire logic data_parity_error_detected_i,
   input wire logic perr_seen_i,
   input wire logic master_phase_i,
   input wire logic master_abort_i,
   input wire logic target_abort_rcvd_i,
   input wire logic target_abort_sent_i,
   // Bus interface controls
   output logic serr_o,
   output logic perr_o,
   output logic memory_space_enable_o,
   output logic initiator_enable_o,
   output logic [3:0] mem_write_cmd_o,
   output logic io_space_claim_o,
   output logic special_cycle_claim_o,
   output logic back_to_back_initiate_o,
   output logic stepping_o,
   output logic palette_snoop_o,
   output logic [1:0] devsel_timing_o
);

   localparam logic [7:0] CMD_OFF = `PLCSR_CMD_OFF;

   function automatic logic cfg_hit(input logic [7:0] a);
      cfg_hit = (a[7:2] == CMD_OFF[7:2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Byte lane write mask
   logic [3:0] lane_we;
   plcsr_word_t wmask;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign lane_we[gi] = cfg_wr_i & cfg_hit(cfg_addr_i) & cfg_be_i[gi];
         assign wmask[gi*8 +: 8] = {8{lane_we[gi]}};
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Command register
   plcsr_half_t cmd_q, cmd_d;
   plcsr_half_t cmd_merged;

   always_comb begin
      cmd_merged = (cmd_q & ~wmask[15:0]) | (cfg_wdata_i[15:0] & wmask[15:0]);
      // Only the five enable bits hold state; the fixed bits drop out here
      cmd_d = cmd_merged & `PLCSR_CMD_WR_MASK;
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cmd_q <= `PLCSR_CMD_RESET;
      end else begin
         cmd_q <= cmd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error drive requests, one cycle after the detected error
   logic serr_q, serr_d;
   logic perr_q, perr_d;

   always_comb begin
      serr_d = addr_parity_error_detected_i & cmd_q[`PLCSR_CMD_SERR_BIT];
      perr_d = data_parity_error_detected_i & cmd_q[`PLCSR_CMD_PERR_BIT];
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         serr_q <= 1'h0;
         perr_q <= 1'h0;
      end else begin
         serr_q <= serr_d;
         perr_q <= perr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky error flags
   plcsr_half_t sticky_q, sticky_d;
   plcsr_half_t sticky_set, sticky_clr;

   always_comb begin
      sticky_set = 16'h0000;
      sticky_set[`PLCSR_ST_PARERR_BIT] = addr_parity_error_detected_i | data_parity_error_detected_i;
      // Set only after the drive request really went out
      sticky_set[`PLCSR_ST_SYSERR_BIT] = serr_q;
      sticky_set[`PLCSR_ST_IABORT_BIT] = master_abort_i;
      sticky_set[`PLCSR_ST_TABREC_BIT] = target_abort_rcvd_i;
      sticky_set[`PLCSR_ST_TABSIG_BIT] = target_abort_sent_i;
      sticky_set[`PLCSR_ST_DPREP_BIT] = perr_seen_i & master_phase_i &
                                        cmd_q[`PLCSR_CMD_PERR_BIT];
      // Write one clears; a same-cycle event wins over the clear
      sticky_clr = cfg_wdata_i[31:16] & wmask[31:16];
      sticky_d = ((sticky_q & ~sticky_clr) | sticky_set) & `PLCSR_ST_W1C_MASK;
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sticky_q <= `PLCSR_ST_STICKY_RESET;
      end else begin
         sticky_q <= sticky_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path
   plcsr_half_t stat_rd;
   logic rvalid_q, rvalid_d;
   plcsr_word_t rdata_q, rdata_d;

   always_comb begin
      // Fixed bits: devsel 01b, capability list 1, the rest zero
      stat_rd = sticky_q | `PLCSR_ST_FIXED;
      rvalid_d = cfg_rd_i;
      // Misses return zero; data stands for the one cycle of the answer
      rdata_d = 32'h0000_0000;
      if (cfg_rd_i && cfg_hit(cfg_addr_i)) begin
         // Reserved bits and read-only zero command bits stay zero
         rdata_d = {stat_rd, cmd_q};
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rvalid_q <= 1'h0;
         rdata_q <= 32'h0000_0000;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign cfg_rvalid_o = rvalid_q;
   assign cfg_rdata_o = rdata_q;
   assign serr_o = serr_q;
   assign perr_o = perr_q;
   assign memory_space_enable_o = cmd_q[`PLCSR_CMD_MEM_BIT];
   assign initiator_enable_o = cmd_q[`PLCSR_CMD_MASTER_BIT];
   assign mem_write_cmd_o = cmd_q[`PLCSR_CMD_MWI_BIT] ?
                            `PLCSR_BUSCMD_MWI : `PLCSR_BUSCMD_MEMWR;
   assign io_space_claim_o = 1'h0;
   assign special_cycle_claim_o = 1'h0;
   assign back_to_back_initiate_o = 1'h0;
   assign stepping_o = 1'h0;
   assign palette_snoop_o = 1'h0;
   assign devsel_timing_o = `PLCSR_DEVSEL_MEDIUM;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   logic clr15;
   assign clr15 = lane_we[3] & cfg_wdata_i[31];

   a_reserved_zero: assert property (
      cfg_rvalid_o |-> (cfg_rdata_o[15:10] == 6'h00) && (cfg_rdata_o[19:16] == 4'h0))
      else $error("reserved bits not zero");

   a_fixed_readback: assert property (
      (cfg_rd_i && cfg_hit(cfg_addr_i)) |=> (cfg_rdata_o[26:25] == 2'h1) &&
      cfg_rdata_o[20] && (cfg_rdata_o[23:21] == 3'h0) && (cfg_rdata_o[9] == 1'b0) &&
      (cfg_rdata_o[7] == 1'b0) && (cfg_rdata_o[5] == 1'b0) &&
      (cfg_rdata_o[3] == 1'b0) && (cfg_rdata_o[0] == 1'b0))
      else $error("fixed bits wrong on read");

   a_cmd_write: assert property (
      (lane_we[0] && lane_we[1]) |=> (cmd_q == ($past(cfg_wdata_i[15:0]) & 16'h0156)))
      else $error("command write not stored");

   a_par_set: assert property (
      (addr_parity_error_detected_i || data_parity_error_detected_i) |=> sticky_q[15])
      else $error("parity flag not set");

   a_w1c_clear: assert property (
      (clr15 && !addr_parity_error_detected_i && !data_parity_error_detected_i) |=> !sticky_q[15])
      else $error("write one did not clear");

   a_sticky_hold: assert property (
      (sticky_q[13] && !(lane_we[3] && cfg_wdata_i[29])) |=> sticky_q[13])
      else $error("sticky flag lost");

   a_serr_gate: assert property (
      serr_o |-> $past(addr_parity_error_detected_i) && $past(cmd_q[8]))
      else $error("serr without enable");

   a_syserr_cause: assert property (
      $rose(sticky_q[14]) |-> $past(serr_o))
      else $error("system error flag without serr");

   a_data_parity_reported_cause: assert property (
      $rose(sticky_q[8]) |-> $past(perr_seen_i && master_phase_i && cmd_q[6]))
      else $error("data parity flag without cause");

   a_perr_gate: assert property (
      (data_parity_error_detected_i && !cmd_q[6]) |=> !perr_o)
      else $error("perr driven while disabled");

   a_abort_set: assert property (
      master_abort_i |=> sticky_q[13] ##1 sticky_q[13] || $past(lane_we[3]))
      else $error("master abort not recorded");

   a_mwi_select: assert property (
      $rose(cmd_q[4]) |-> (mem_write_cmd_o == 4'hF))
      else $error("write invalidate not selected");

   a_serr_drive: assert property (
      (addr_parity_error_detected_i && cmd_q[8]) |=> serr_o)
      else $error("serr not driven while enabled");

   a_serr_quiet: assert property (
      (addr_parity_error_detected_i && !cmd_q[8]) |=> !serr_o)
      else $error("serr driven while disabled");

   a_perr_drive: assert property (
      (data_parity_error_detected_i && cmd_q[6]) |=> perr_o)
      else $error("perr not driven while enabled");

   a_syserr_gate: assert property (
      (!sticky_q[14] && !serr_o) |=> !sticky_q[14])
      else $error("system error flag rose while serr idle");

   a_tabrec_set: assert property (
      target_abort_rcvd_i |=> sticky_q[12])
      else $error("received target abort not recorded");

   a_tabsig_set: assert property (
      target_abort_sent_i |=> sticky_q[11])
      else $error("signaled target abort not recorded");

   a_data_parity_reported_gate: assert property (
      (!sticky_q[8] && !(perr_seen_i && master_phase_i && cmd_q[6])) |=> !sticky_q[8])
      else $error("data parity flag set without all conditions");

   a_initiator_hold: assert property (
      !lane_we[0] |=> $stable(initiator_enable_o))
      else $error("initiator enable changed without write");

   a_memory_hold: assert property (
      !lane_we[0] |=> $stable(memory_space_enable_o))
      else $error("memory enable changed without write");

   a_cmd_keep: assert property (
      (!lane_we[0] && !lane_we[1]) |=> $stable(cmd_q))
      else $error("command changed without write");

   a_miss_zero: assert property (
      (cfg_rd_i && !cfg_hit(cfg_addr_i)) |=> (cfg_rdata_o == 32'h0000_0000))
      else $error("missed read not zero");

   c_mem_enable: cover property ($rose(memory_space_enable_o));
   c_flag_clear: cover property (sticky_q[15] ##1 clr15 ##1 !sticky_q[15]);
   c_set_wins: cover property (clr15 && addr_parity_error_detected_i);
   c_serr_pulse: cover property (serr_o);
   c_data_parity_reported_set: cover property ($rose(sticky_q[8]));

endmodule // plcsr_regs

// ### sim/plcsr_bus_agent_model.sv
`timescale 1ns/1ps
module plcsr_bus_agent_model (
   // Clock
   input wire logic clock_i,
   // Bench requests and device state
   input wire logic [6:0] req_i,
   input wire logic initiator_enable_i,
   // Bus events
   output logic addr_parity_error_detected_o,
   output logic data_parity_error_detected_o,
   output logic perr_seen_o,
   output logic master_phase_o,
   output logic master_abort_o,
   output logic target_abort_rcvd_o,
   output logic target_abort_sent_o
);
   // Aborts as initiator only happen if the device may master the bus
   always @(posedge clock_i) begin
      {addr_parity_error_detected_o, data_parity_error_detected_o, perr_seen_o, target_abort_sent_o} <= req_i[3:0];
      master_phase_o <= req_i[4];
      master_abort_o <= req_i[5] & initiator_enable_i;
      target_abort_rcvd_o <= req_i[6] & initiator_enable_i;
   end
endmodule // plcsr_bus_agent_model

// ### sim/test_pci_link_command_status_regs.sv
`timescale 1ns/1ps
module test_pci_link_command_status_regs;
   import plcsr_pkg::*;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cfg_rd_i = 1'b0;
   logic cfg_wr_i = 1'b0;
   logic [7:0] cfg_addr_i = 8'h00;
   logic [3:0] cfg_be_i = 4'h0;
   plcsr_word_t cfg_wdata_i = 32'h0000_0000;
   logic [6:0] req = 7'h00;
   logic rvalid, serr_o, perr_o, mse, ien, io, sc, b2b, st, pal;
   logic ape, dpe, pse, mph, mab, tar, tas;
   logic [3:0] mwc;
   logic [1:0] dev;
   plcsr_word_t rdata;
   int mismatches = 0;
   int n_tests = 0;
   always #5 clock_i = ~clock_i;
   plcsr_bus_agent_model agent (.clock_i(clock_i), .req_i(req), .initiator_enable_i(ien),
      .addr_parity_error_detected_o(ape), .data_parity_error_detected_o(dpe), .perr_seen_o(pse), .master_phase_o(mph),
      .master_abort_o(mab), .target_abort_rcvd_o(tar), .target_abort_sent_o(tas));
   plcsr_regs dut (.clock_i(clock_i), .resetn_i(resetn_i), .cfg_rd_i(cfg_rd_i),
      .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
      .cfg_wdata_i(cfg_wdata_i), .cfg_rvalid_o(rvalid), .cfg_rdata_o(rdata),
      .addr_parity_error_detected_i(ape), .data_parity_error_detected_i(dpe), .perr_seen_i(pse), .master_phase_i(mph),
      .master_abort_i(mab), .target_abort_rcvd_i(tar), .target_abort_sent_i(tas),
      .serr_o(serr_o), .perr_o(perr_o), .memory_space_enable_o(mse),
      .initiator_enable_o(ien), .mem_write_cmd_o(mwc), .io_space_claim_o(io),
      .special_cycle_claim_o(sc), .back_to_back_initiate_o(b2b), .stepping_o(st),
      .palette_snoop_o(pal), .devsel_timing_o(dev));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input plcsr_word_t got, input plcsr_word_t exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %0s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input plcsr_word_t exp);
      @(posedge clock_i) #1;
      cfg_rd_i = 1'b1;
      cfg_addr_i = a;
      @(posedge clock_i) #1;
      cfg_rd_i = 1'b0;
      chk({31'h0, rvalid}, 32'h0000_0001, "read valid");
      chk(rdata, exp, "read data");
   endtask
   task automatic wr(input logic [3:0] be, input plcsr_word_t d);
      @(posedge clock_i) #1;
      cfg_wr_i = 1'b1;
      cfg_addr_i = 8'h04;
      cfg_be_i = be;
      cfg_wdata_i = d;
      @(posedge clock_i) #1;
      cfg_wr_i = 1'b0;
   endtask
   // Event reaches the device one edge after the request, drive shows one edge later
   task automatic ev(input logic [6:0] r, input logic [1:0] exp);
      @(posedge clock_i) #1;
      req = r;
      @(posedge clock_i) #1;
      req = 7'h00;
      @(posedge clock_i) #1;
      chk({30'h0, serr_o, perr_o}, {30'h0, exp}, "error drive");
   endtask
   function automatic plcsr_word_t outs();
      return {19'h0, mse, ien, mwc, io, sc, b2b, st, pal, dev};
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clock_i);
      #1 resetn_i = 1'b1;
      rd(8'h04, 32'h0210_0000);
      $display("test reset done");
      wr(4'hF, 32'hFFFF_FFFF);
      rd(8'h04, 32'h0210_0156);
      chk(outs(), {19'h0, 1'h1, 1'h1, 4'hF, 5'h00, 2'h1}, "controls");
      $display("test write done");
      ev(7'h08, 2'h2);
      ev(7'h04, 2'h1);
      ev(7'h12, 2'h0);
      ev(7'h61, 2'h0);
      rd(8'h04, 32'hFB10_0156);
      $display("test events done");
      wr(4'hC, 32'h0000_0000);
      rd(8'h04, 32'hFB10_0156);
      wr(4'hC, 32'hFFFF_0000);
      rd(8'h04, 32'h0210_0156);
      $display("test clear done");
      wr(4'h3, 32'h0000_0010);
      chk(outs(), {19'h0, 1'h0, 1'h0, 4'hF, 5'h00, 2'h1}, "controls");
      wr(4'h3, 32'h0000_0000);
      chk(outs(), {19'h0, 1'h0, 1'h0, 4'h7, 5'h00, 2'h1}, "controls");
      ev(7'h08, 2'h0);
      ev(7'h04, 2'h0);
      ev(7'h12, 2'h0);
      rd(8'h04, 32'h8210_0000);
      $display("test disabled done");
      rd(8'h08, 32'h0000_0000);
      $display("test miss done");
      // Mid-run reset must drop the sticky parity flag again
      @(posedge clock_i) #1;
      resetn_i = 1'b0;
      @(posedge clock_i) #1;
      resetn_i = 1'b1;
      rd(8'h04, 32'h0210_0000);
      chk(outs(), {19'h0, 1'h0, 1'h0, 4'h7, 5'h00, 2'h1}, "controls");
      $display("test second reset done");
      stop_test();
   end
   initial begin
      #20000;
      mismatches++;
      stop_test();
   end
endmodule // test_pci_link_command_status_regs
